// ==== hdl/tcc_top.sv ====
// Purpose: four general registers of one timer channel, capture and compare
// Assumes: counter comes from same clock domain and advances once per enabled cycle
// Notes: zero wait state AHB-Lite slave; response always OKAY
//
// Decided for this implementation: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/100ps
module tcc_top (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic clk_en_i,
  input wire logic hsel_i,
  input wire logic [7:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic [15:0] channel_counter_i,
  input wire logic [3:0] timer_pin_i,
  output logic [3:0] timer_pin_o,
  output logic [3:0] timer_pin_oe_o
);
  logic [15:0] gr_q [4];
  logic [15:0] ctl_q;
  logic [3:0] flag_q;
  logic [3:0] seen_q;
  logic [3:0] s1_q, s2_q, s3_q;
  logic [3:0] pin_q, oe_q;
  logic wr_q;
  logic [7:0] wad_q;
  logic [31:0] rd_q;
  logic [3:0] cap, match, rise, fall;
  logic [3:0] mode;
  logic [1:0] sel [4];
  logic fsc, fsd, bfc, bfd;
  logic acc, wr_en;
  logic [31:0] rd_d;

  assign mode = ctl_q[tcc_pkg::CTL_MODE +: 4];
  assign fsc = ctl_q[tcc_pkg::CTL_FSC];
  assign fsd = ctl_q[tcc_pkg::CTL_FSD];
  assign bfc = ctl_q[tcc_pkg::CTL_BFC];
  assign bfd = ctl_q[tcc_pkg::CTL_BFD];
  assign acc = hsel_i && hready_i && htrans_i == tcc_pkg::HTR_NONSEQ;
  assign wr_en = wr_q && clk_en_i;

  // Pin synchroniser; stage one feeds stage two, which feeds stage three
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_q <= 4'h0;
      s2_q <= 4'h0;
      s3_q <= 4'h0;
    end else if (clk_en_i) begin
      s1_q <= timer_pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Per-register edge qualify and compare detect
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_ch
      assign sel[g] = ctl_q[tcc_pkg::CTL_SEL + 2 * g +: 2];
      assign rise[g] = s2_q[g] && !s3_q[g];
      assign fall[g] = !s2_q[g] && s3_q[g];
      assign cap[g] = clk_en_i && mode[g] && (g < 2 || !(g == 2 ? bfc : bfd)) &&
        ((sel[g] == tcc_pkg::EDG_RISE && rise[g]) ||
         (sel[g] == tcc_pkg::EDG_FALL && fall[g]) ||
         (sel[g] == tcc_pkg::EDG_BOTH && (rise[g] || fall[g])));
      assign match[g] = clk_en_i && !mode[g] && channel_counter_i == gr_q[g] &&
        (g < 2 || !((g == 2 ? bfc : bfd) && (g == 2 ? fsc : fsd)));
    end
  endgenerate

  // Read mux, evaluated in the address phase
  always_comb begin
    rd_d = 32'h0000_0000;
    case (haddr_i)
      tcc_pkg::OFS_GRA: rd_d[15:0] = gr_q[0];
      tcc_pkg::OFS_GRB: rd_d[15:0] = gr_q[1];
      tcc_pkg::OFS_GRC: rd_d[15:0] = gr_q[2];
      tcc_pkg::OFS_GRD: rd_d[15:0] = gr_q[3];
      tcc_pkg::OFS_CTRL: rd_d[15:0] = ctl_q;
      tcc_pkg::OFS_STAT: rd_d[7:0] = {pin_q, flag_q};
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // Bus slave: address phase latch, registered read data
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_q <= 1'b0;
      wad_q <= 8'h00;
      rd_q <= 32'h0000_0000;
      hreadyout_o <= 1'b0;
      hresp_o <= 1'b0;
    end else if (clk_en_i) begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      if (hready_i) begin
        wr_q <= acc && hwrite_i;
        wad_q <= haddr_i;
        rd_q <= (acc && !hwrite_i) ? rd_d : 32'h0000_0000;
      end
    end
  end
  assign hrdata_o = rd_q;

  // Control word, software only
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctl_q <= tcc_pkg::CTL_RST;
    end else if (wr_en && wad_q == tcc_pkg::OFS_CTRL) begin
      ctl_q <= hwdata_i[tcc_pkg::CTL_W-1:0];
    end
  end

  // General registers A and B
  // Capture beats buffer load, which beats software
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      gr_q[0] <= tcc_pkg::GR_RST;
      gr_q[1] <= tcc_pkg::GR_RST;
    end else begin
      if (cap[0]) begin
        gr_q[0] <= channel_counter_i;
      end else if (match[0] && bfc && fsc) begin
        gr_q[0] <= gr_q[2];
      end else if (wr_en && wad_q == tcc_pkg::OFS_GRA) begin
        gr_q[0] <= hwdata_i[15:0];
      end
      if (cap[1]) begin
        gr_q[1] <= channel_counter_i;
      end else if (match[1] && bfd && fsd) begin
        gr_q[1] <= gr_q[3];
      end else if (wr_en && wad_q == tcc_pkg::OFS_GRB) begin
        gr_q[1] <= hwdata_i[15:0];
      end
    end
  end

  // General registers C and D
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      gr_q[2] <= tcc_pkg::GR_RST;
      gr_q[3] <= tcc_pkg::GR_RST;
    end else begin
      if (cap[2]) begin
        gr_q[2] <= channel_counter_i;
      end else if (cap[0] && bfc) begin
        gr_q[2] <= gr_q[0];
      end else if (wr_en && wad_q == tcc_pkg::OFS_GRC) begin
        gr_q[2] <= hwdata_i[15:0];
      end
      if (cap[3]) begin
        gr_q[3] <= channel_counter_i;
      end else if (cap[1] && bfd) begin
        gr_q[3] <= gr_q[1];
      end else if (wr_en && wad_q == tcc_pkg::OFS_GRD) begin
        gr_q[3] <= hwdata_i[15:0];
      end
    end
  end

  function automatic logic act(input logic lvl, input logic [1:0] a);
    act = lvl;
    case (a)
      tcc_pkg::ACT_LOW: act = 1'b0;
      tcc_pkg::ACT_HIGH: act = 1'b1;
      tcc_pkg::ACT_TGL: act = !lvl;
      default: act = lvl;
    endcase
  endfunction

  // Compare outputs; C and D may steer pins A and B instead
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_q <= 4'h0;
      oe_q <= 4'h0;
    end else if (clk_en_i) begin
      if (match[0]) begin
        pin_q[0] <= act(pin_q[0], sel[0]);
      end else if (match[2] && !fsc && !bfc) begin
        pin_q[0] <= act(pin_q[0], sel[2]);
      end
      if (match[1]) begin
        pin_q[1] <= act(pin_q[1], sel[1]);
      end else if (match[3] && !fsd && !bfd) begin
        pin_q[1] <= act(pin_q[1], sel[3]);
      end
      // plain compare on C and D
      if (match[2] && fsc && !bfc) begin
        pin_q[2] <= act(pin_q[2], sel[2]);
      end
      if (match[3] && fsd && !bfd) begin
        pin_q[3] <= act(pin_q[3], sel[3]);
      end
      oe_q[0] <= !mode[0] && sel[0] != tcc_pkg::ACT_NONE;
      oe_q[1] <= !mode[1] && sel[1] != tcc_pkg::ACT_NONE;
      oe_q[2] <= !mode[2] && fsc && !bfc && sel[2] != tcc_pkg::ACT_NONE;
      oe_q[3] <= !mode[3] && fsd && !bfd && sel[3] != tcc_pkg::ACT_NONE;
    end
  end
  assign timer_pin_o = pin_q;
  assign timer_pin_oe_o = oe_q;

  // Sticky flags: a flag clears only if read while set; set wins
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flag_q <= 4'h0;
      seen_q <= 4'h0;
    end else if (clk_en_i) begin
      for (int i = 0; i < 4; i++) begin
        // set on event, read then write 0
        if (cap[i] || match[i]) begin
          flag_q[i] <= 1'b1;
        end else if (wr_q && wad_q == tcc_pkg::OFS_STAT && seen_q[i] && !hwdata_i[i]) begin
          flag_q[i] <= 1'b0;
          seen_q[i] <= 1'b0;
        end
        if (hready_i && acc && !hwrite_i && haddr_i == tcc_pkg::OFS_STAT && flag_q[i]) begin
          seen_q[i] <= 1'b1;
        end
      end
    end
  end

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  mode_c_cap_a: assert property (cap[2] |=> gr_q[2] == $past(channel_counter_i))
    else $error("capture into C lost");
  gr_write_a: assert property (wr_en && wad_q == tcc_pkg::OFS_GRB && !cap[1] && !(match[1] && bfd && fsd)
    |=> gr_q[1] == $past(hwdata_i[15:0]))
    else $error("write to B not stored");
  cmp_b_high_a: assert property (match[1] && sel[1] == tcc_pkg::ACT_HIGH |=> timer_pin_o[1])
    else $error("pin B not high after match");
  cmp_d_flag_a: assert property (match[3] |=> flag_q[3])
    else $error("match D not flagged");
  gen_c_low_a: assert property (match[2] && fsc && !bfc && sel[2] == tcc_pkg::ACT_LOW
    |=> !timer_pin_o[2])
    else $error("pin C not low after match");
  buf_load_a: assert property (match[0] && bfc && fsc && !cap[0] |=> gr_q[0] == $past(gr_q[2]))
    else $error("A not reloaded from C");
  ctrl_c_tgl_a: assert property (match[2] && !fsc && !bfc && !match[0] && sel[2] == tcc_pkg::ACT_TGL
    |=> timer_pin_o[0] != $past(timer_pin_o[0]))
    else $error("C did not toggle pin A");
  cap_b_latch_a: assert property (cap[1] |=> gr_q[1] == $past(channel_counter_i) && flag_q[1])
    else $error("capture B wrong");
  cap_buf_a: assert property (cap[0] && bfc |=> gr_q[2] == $past(gr_q[0]))
    else $error("C did not take old A");
  edge_sel_a: assert property (cap[0] |-> (sel[0] == tcc_pkg::EDG_RISE && rise[0]) ||
    (sel[0] == tcc_pkg::EDG_FALL && fall[0]) || (sel[0] == tcc_pkg::EDG_BOTH && (rise[0] || fall[0])))
    else $error("capture A on wrong edge");
  flag_a_set_a: assert property (cap[0] |=> flag_q[0])
    else $error("flag A not set");
  match_eq_a: assert property (match[1] |-> channel_counter_i == gr_q[1] && !mode[1])
    else $error("false match B");

  // Capture into D takes the counter of that cycle
  cap_d_latch_a: assert property (cap[3] |=> gr_q[3] == $past(channel_counter_i))
    else $error("capture into D lost");

  // Capture into A wins over a same-cycle write
  cap_a_win_a: assert property (cap[0] |=> gr_q[0] == $past(channel_counter_i))
    else $error("capture A lost to write");

  // D keeps the old B value when B captures
  buf_d_cap_a: assert property (cap[1] && bfd |=> gr_q[3] == $past(gr_q[1]))
    else $error("D did not take old B");

  // B reloads from its buffer D on a B match
  buf_d_load_a: assert property (match[1] && bfd && fsd && !cap[1] |=> gr_q[1] == $past(gr_q[3]))
    else $error("B not reloaded from D");

  // A buffered C never captures from its own pin
  cap_c_block_a: assert property (bfc |-> !cap[2])
    else $error("buffered C captured");

  // Reserved edge code must never capture
  edge_rsv_a: assert property (sel[0] == 2'h3 |-> !cap[0])
    else $error("capture on reserved code");

  // Low action drives pin B low
  act_low_b_a: assert property (match[1] && sel[1] == tcc_pkg::ACT_LOW |=> !timer_pin_o[1])
    else $error("pin B not low after match");

  // Toggle action inverts pin B
  act_tgl_b_a: assert property (match[1] && sel[1] == tcc_pkg::ACT_TGL
    |=> timer_pin_o[1] != $past(timer_pin_o[1]))
    else $error("pin B did not toggle");

  // No action leaves pin B alone
  act_none_b_a: assert property (match[1] && sel[1] == tcc_pkg::ACT_NONE |=> $stable(timer_pin_o[1]))
    else $error("pin B moved without action");

  // Plain compare on D drives pin D high
  cmp_d_high_a: assert property (match[3] && fsd && !bfd && sel[3] == tcc_pkg::ACT_HIGH |=> timer_pin_o[3])
    else $error("pin D not high after match");

  // D as output control steers pin B
  ctrl_d_pin_a: assert property (match[3] && !fsd && !bfd && !match[1] && sel[3] == tcc_pkg::ACT_HIGH
    |=> timer_pin_o[1])
    else $error("D did not drive pin B");

  // Flag A stays set until the read-then-write clear
  flag_hold_a: assert property (flag_q[0] && !(wr_q && wad_q == tcc_pkg::OFS_STAT && seen_q[0] && !hwdata_i[0])
    |=> flag_q[0])
    else $error("flag A lost");

  // Read-then-write 0 clears flag A when no event competes
  flag_clr_a: assert property (clk_en_i && wr_q && wad_q == tcc_pkg::OFS_STAT && seen_q[0] && !hwdata_i[0] &&
    !cap[0] && !match[0] |=> !flag_q[0])
    else $error("flag A not cleared");

  // Enable low is not a count cycle: nothing moves
  freeze_a: assert property (!clk_en_i |=> $stable(timer_pin_o) && $stable(flag_q) && $stable(gr_q[0]))
    else $error("state moved while frozen");

  // Equal counter in compare mode must match
  match_b_a: assert property (clk_en_i && !mode[1] && channel_counter_i == gr_q[1] |-> match[1])
    else $error("missed match B");

  // Pin B is driven while compare B has an action
  oe_b_a: assert property (clk_en_i && !mode[1] && sel[1] != tcc_pkg::ACT_NONE |=> timer_pin_oe_o[1])
    else $error("pin B not driven");

  // Bus response is always OKAY
  hresp_okay_a: assert property (!hresp_o)
    else $error("error response seen");
endmodule // tcc_top

// ==== inc/tcc_pkg.sv ====
// Purpose: constants for the timer capture/compare register block
// Assumes: 32-bit AHB-Lite slave, one aligned word per register
// Notes: offsets, control fields and codes shared by design and bench
package tcc_pkg;
  // Byte offsets of the register map
  localparam logic [7:0] OFS_GRA = 8'h00;
  localparam logic [7:0] OFS_GRB = 8'h04;
  localparam logic [7:0] OFS_GRC = 8'h08;
  localparam logic [7:0] OFS_GRD = 8'h0C;
  localparam logic [7:0] OFS_CTRL = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  // Control word fields
  localparam int CTL_MODE = 0;   // 4 bits, 1 = capture
  localparam int CTL_SEL = 4;    // 8 bits, 2 per register
  localparam int CTL_FSC = 12;
  localparam int CTL_FSD = 13;
  localparam int CTL_BFC = 14;
  localparam int CTL_BFD = 15;
  localparam int CTL_W = 16;
  localparam logic [15:0] CTL_RST = 16'h3000;
  localparam logic [15:0] GR_RST = 16'hFFFF;
  // Status word fields
  localparam int STA_FLAG = 0;   // 4 sticky flags
  localparam int STA_PIN = 4;    // 4 pin levels
  // Edge select and output action codes
  localparam logic [1:0] EDG_RISE = 2'h0;
  localparam logic [1:0] EDG_FALL = 2'h1;
  localparam logic [1:0] EDG_BOTH = 2'h2;
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_LOW = 2'h1;
  localparam logic [1:0] ACT_HIGH = 2'h2;
  localparam logic [1:0] ACT_TGL = 2'h3;
  // Example compare values for 1 ms and 2 ms
  localparam logic [15:0] EX_CMP_B = 16'h3E7F;
  localparam logic [15:0] EX_CMP_D = 16'h7CFF;
  localparam logic [1:0] HTR_NONSEQ = 2'h2;
endpackage

// ==== tb/tb.sv ====
// Purpose: self-checking bench for the capture/compare register block
// Assumes: zero wait bus; counter value is driven by the bench
// Notes: counter held still around pin edges so captured values are exact
`timescale 1ns/100ps
module tb;
  logic sys_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic rdy;
  logic hresp;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [15:0] cnt = 16'h8000;
  logic [3:0] drv = 4'h0;
  logic en = 1'b1;
  logic [3:0] pin;
  logic [3:0] po;
  logic [3:0] poe;
  logic [1:0] acts [4] = '{tcc_pkg::ACT_HIGH, tcc_pkg::ACT_LOW, tcc_pkg::ACT_TGL, tcc_pkg::ACT_NONE};
  logic [3:0] pexp [4] = '{4'h3, 4'h2, 4'h3, 4'h0};
  int miscompares = 0;
  int checks_done = 0;
  tcc_top uut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .clk_en_i(en), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(rdy),
    .hrdata_o(hrdata), .hreadyout_o(rdy), .hresp_o(hresp), .channel_counter_i(cnt),
    .timer_pin_i(pin), .timer_pin_o(po), .timer_pin_oe_o(poe));
  tcc_pins pins (.drv_i(drv), .pin_out_i(po), .pin_oe_i(poe), .pin_o(pin));
  // Free-running 250 MHz clock
  initial begin
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %0t: read %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkp(input logic [3:0] got, input logic [3:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %0t: pins %b expected %b", $time, got, exp);
    end
  endtask
  // One single transfer; request held until ready is seen high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= tcc_pkg::HTR_NONSEQ;
    do @(posedge sys_clk_i); while (rdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk_i); while (rdy !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask
  // Pin level change, then enough edges for sync and capture
  task automatic pin_to(input logic [3:0] l);
    drv <= l;
    cyc(6);
  endtask
  // Counter shows v for exactly one edge, so toggles fire once
  task automatic hit(input logic [15:0] v);
    cnt <= v;
    cyc(1);
    cnt <= 16'h8000;
    cyc(3);
  endtask
  task automatic fin(input string n);
    $display("Test %s done", n);
  endtask
  task automatic results();
    $display("Checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Watchdog: the whole run needs a few hundred cycles
  initial begin
    cyc(20000);
    miscompares++;
    results();
  end
  // Test sequence
  initial begin
    cyc(5);
    nrst_i <= 1'b1;
    cyc(2);
    for (int i = 0; i < 4; i++) begin
      rdc(8'(4 * i), 32'hFFFF, {16'h0, tcc_pkg::GR_RST});
      wr(8'(4 * i), 32'h0);
      rdc(8'(4 * i), 32'hFFFFFFFF, 32'h0);
    end
    rdc(tcc_pkg::OFS_CTRL, 32'hFFFF, {16'h0, tcc_pkg::CTL_RST});
    rdc(8'h18, 32'hFFFFFFFF, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    fin("registers");
    for (int c = 0; c < 4; c++) begin
      wr(tcc_pkg::OFS_CTRL, 32'h3001 | (c << 4));
      wr(tcc_pkg::OFS_GRA, 32'h0);
      cnt <= 16'h1111;
      pin_to(4'h1);
      cnt <= 16'h2222;
      pin_to(4'h0);
      rdc(tcc_pkg::OFS_GRA, 32'hFFFF, c == 0 ? 32'h1111 : (c == 3 ? 32'h0 : 32'h2222));
      rdc(tcc_pkg::OFS_STAT, 32'h1, c == 3 ? 32'h0 : 32'h1);
      wr(tcc_pkg::OFS_STAT, 32'h0);
      rdc(tcc_pkg::OFS_STAT, 32'h1, 32'h0);
    end
    wr(tcc_pkg::OFS_CTRL, 32'h3004);
    cnt <= 16'h4321;
    pin_to(4'h4);
    pin_to(4'h0);
    rdc(tcc_pkg::OFS_GRC, 32'hFFFF, 32'h4321);
    wr(tcc_pkg::OFS_CTRL, 32'h5005);
    wr(tcc_pkg::OFS_GRA, 32'h0ABC);
    cnt <= 16'h5555;
    pin_to(4'h1);
    pin_to(4'h0);
    rdc(tcc_pkg::OFS_GRA, 32'hFFFF, 32'h5555);
    rdc(tcc_pkg::OFS_GRC, 32'hFFFF, 32'h0ABC);
    fin("capture");
    wr(tcc_pkg::OFS_GRB, {16'h0, tcc_pkg::EX_CMP_B});
    for (int k = 0; k < 4; k++) begin
      wr(tcc_pkg::OFS_CTRL, 32'h3000 | (acts[k] << 6));
      if (k == 0) begin
        hit(tcc_pkg::EX_CMP_B - 16'h1);
        chkp({2'b0, poe[1], po[1] & poe[1]}, 4'h2);
      end
      hit(tcc_pkg::EX_CMP_B);
      chkp({2'b0, poe[1], po[1] & poe[1]}, pexp[k]);
    end
    wr(tcc_pkg::OFS_CTRL, 32'h3800);
    wr(tcc_pkg::OFS_GRD, {16'h0, tcc_pkg::EX_CMP_D});
    hit(tcc_pkg::EX_CMP_D);
    chkp({2'b0, poe[3], po[3]}, 4'h3);
    wr(tcc_pkg::OFS_CTRL, 32'h7000);
    wr(tcc_pkg::OFS_GRA, 32'h0100);
    wr(tcc_pkg::OFS_GRC, 32'h0200);
    hit(16'h0100);
    rdc(tcc_pkg::OFS_GRA, 32'hFFFF, 32'h0200);
    wr(tcc_pkg::OFS_CTRL, 32'h1440);
    hit(tcc_pkg::EX_CMP_B);
    wr(tcc_pkg::OFS_CTRL, 32'h1880);
    wr(tcc_pkg::OFS_GRD, 32'h0300);
    hit(16'h0300);
    chkp({2'b0, poe[1], po[1]}, 4'h3);
    // Enable low is no count cycle: a low action must not land
    wr(tcc_pkg::OFS_CTRL, 32'h1440);
    en <= 1'b0;
    hit(tcc_pkg::EX_CMP_B);
    en <= 1'b1;
    cyc(1);
    chkp({2'b0, poe[1], po[1]}, 4'h3);
    fin("compare");
    results();
  end
endmodule // tb

// ==== tb/tcc_pins.sv ====
// Purpose: external pin model for the capture/compare block
// Assumes: bench sets the level an outside source would drive
// Notes: device output wins while its enable is high, as on a shared pin
`timescale 1ns/100ps
module tcc_pins (
  input wire logic [3:0] drv_i,
  input wire logic [3:0] pin_out_i,
  input wire logic [3:0] pin_oe_i,
  output logic [3:0] pin_o
);
  // Resolve each pin from the device enable and the outside source
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin_o[i] = pin_oe_i[i] ? pin_out_i[i] : drv_i[i];
    end
  end
endmodule // tcc_pins
